/* hw/csfr_bank.sv */
// Register bank: direct-address space, data pointers, EXTERNAL_DATA_MOVE routing, timers 0 and 1
`timescale 1ns/1ns
// How it works
// - Enabled RAM serves EXTERNAL_DATA_MOVE 0000H-03FFH internally
// - Enabled RAM: EXTERNAL_DATA_MOVE above 03FFH goes external
// - Disabled RAM: all EXTERNAL_DATA_MOVE go external
// - 256-byte scratchpad, indirect throughout, direct only below 80h
// - Registers 80h-FFh, direct addressing only
// - Bit access only at addresses ending 0/8
// - Unimplemented registers and bits read one, except pointer select bits 1-7
// - Stack pointer at 81h
// - Pointer select bit 0 picks pointer pair
// - Pointer select bits 1-7 read zero
// - Baud doubling bit doubles serial rate
// - Framing-error select redefines serial bit 7
// - Power down stops all clocks
// - Idle stops CPU clock only
// - Overflow flags set on overflow, cleared on vector
// - Timers count only while run bit set
// - External flags: edge cleared on vector, level follows
// - Type bit: one falling edge, zero low level
// - Gate bit needs pin high plus run
// - Counter select: clock or pin falling edge
// - Modes: prescaled 8, 16-bit, auto-reload
// - Mode 3 splits timer 0, stops timer 1
// - RAM enable bit in power management, reset clear
// - Clock select: divide by 4 or 12
module csfr_bank
	import csfr_pkg::*;
(
	input  wire logic            core_clk,
	input  wire logic            arst_n,
	input  wire csfr_dir_req_t   dir_req,
	input  wire logic            dir_indirect,
	output logic [7:0]           dir_rdata,
	input  wire csfr_xdata_req_t xdata_req,
	output logic [7:0]           xdata_rdata,
	output logic                 xdata_ack,
	output csfr_ext_bus_t        ext_bus,
	input  wire logic [7:0]      ext_rdata,
	input  wire logic [1:0]      vector_timer,
	input  wire logic [1:0]      vector_ext,
	input  wire logic [1:0]      external_interrupt_pin,
	input  wire logic [1:0]      count_pin,
	output logic [15:0]          active_data_pointer,
	output logic                 baud_double,
	output logic                 framing_error_select,
	output logic                 cpu_clk_en,
	output logic                 periph_clk_en
);

	// ---------------------------------------------
	// Storage
	// ---------------------------------------------
	logic [7:0] scratch_ram [SCRATCH_WORDS];
	logic [7:0] int_ram     [INT_RAM_WORDS];
	logic [7:0] scratch_q;
	logic [7:0] int_ram_q;
	csfr_state_t st;
	csfr_state_t next_st;
	logic        sfr_hit;
	logic        bit_ok;
	logic        ram_hit;
	logic [7:0]  sfr_read;
	logic [7:0]  merged;
	logic [1:0]  tick;
	logic [1:0]  run;
	logic [1:0]  t0_mode;
	logic [1:0]  t1_mode;
	logic        t1_tick;
	logic [1:0]  ovf;
	logic [8:0]  sum_lo;
	logic [8:0]  sum_hi;
	logic [1:0]  fall_int;

	assign sfr_hit = dir_req.addr[7] && !dir_indirect;
	assign bit_ok  = dir_req.addr[2:0] == 3'h0;
	assign ram_hit = st.internal_ram_enable && xdata_req.addr <= INT_RAM_LAST;
	assign scratch_q = scratch_ram[dir_req.addr];

	// ---------------------------------------------
	// Scratchpad and on-chip data RAM
	// ---------------------------------------------
	always_ff @(posedge core_clk) begin
		if ((dir_req.wr && !sfr_hit) && st.cpu_clk_en) begin
			scratch_ram[dir_req.addr] <= dir_req.wdata;
		end
		if (xdata_req.wr && ram_hit && st.cpu_clk_en) begin
			int_ram[xdata_req.addr[9:0]] <= xdata_req.wdata;
		end
		int_ram_q <= int_ram[xdata_req.addr[9:0]];
	end

	// ---------------------------------------------
	// Register read mux
	// ---------------------------------------------
	always_comb begin
		case (dir_req.addr)
			ADDR_PORT0_LATCH:    sfr_read = st.port0_latch;
			ADDR_STACK_POINTER:  sfr_read = st.stack_pointer;
			ADDR_POINTER0_LOW:   sfr_read = st.pointer0_low;
			ADDR_POINTER0_HIGH:  sfr_read = st.pointer0_high;
			ADDR_POINTER1_LOW:   sfr_read = st.pointer1_low;
			ADDR_POINTER1_HIGH:  sfr_read = st.pointer1_high;
			ADDR_POINTER_SELECT: sfr_read = {7'h00, st.pointer_select};
			ADDR_POWER_CONTROL:  sfr_read = st.power_control | ~POWER_CONTROL_IMPL_MASK;
			ADDR_TIMER_CONTROL:  sfr_read = st.timer_control;
			ADDR_TIMER_MODE:     sfr_read = st.timer_mode;
			ADDR_TIMER0_LOW:     sfr_read = st.timer0_low_byte;
			ADDR_TIMER1_LOW:     sfr_read = st.timer1_low_byte;
			ADDR_TIMER0_HIGH:    sfr_read = st.timer0_high_byte;
			ADDR_TIMER1_HIGH:    sfr_read = st.timer1_high_byte;
			ADDR_CLOCK_CONTROL:  sfr_read = st.clock_control;
			ADDR_POWER_MGMT:     sfr_read = {7'h7F, st.internal_ram_enable};
			default:             sfr_read = UNIMPL_READ;
		endcase
		merged = sfr_read;
		merged[dir_req.bit_sel] = dir_req.wdata[0];
	end

	// ---------------------------------------------
	// Timer tick and counting conditions
	// ---------------------------------------------
	always_comb begin
		t0_mode = st.timer_mode[1:0];
		t1_mode = st.timer_mode[5:4];
		for (int i = 0; i < 2; i++) begin
			fall_int[i] = st.int_pin_d[i] && !st.int_pin_s[i];
			if (st.timer_mode[4 * i + TM_COUNTER]) begin
				tick[i] = st.cnt_pin_d[i] && !st.cnt_pin_s[i];
			end else if (st.clock_control[CK_T0_CLOCK + i]) begin
				tick[i] = st.div_fast == DIV_FAST_LAST;
			end else begin
				tick[i] = st.div_slow == DIV_SLOW_LAST;
			end
			tick[i] = tick[i] && st.periph_clk_en;
			run[i] = st.timer_control[TC_TR0 + 2 * i] &&
				(!st.timer_mode[4 * i + TM_GATE] || st.int_pin_s[i]);
		end
		t1_tick = (st.clock_control[CK_T1_CLOCK] ? st.div_fast == DIV_FAST_LAST :
			st.div_slow == DIV_SLOW_LAST) && st.periph_clk_en;
	end

	// ---------------------------------------------
	// Next state
	// ---------------------------------------------
	always_comb begin
		next_st = st;
		ovf = 2'b00;
		sum_lo = 9'h000;
		sum_hi = 9'h000;

		// Synchronisers for pins
		next_st.int_pin_q = external_interrupt_pin;
		next_st.int_pin_s = st.int_pin_q;
		next_st.int_pin_d = st.int_pin_s;
		next_st.cnt_pin_q = count_pin;
		next_st.cnt_pin_s = st.cnt_pin_q;
		next_st.cnt_pin_d = st.cnt_pin_s;

		// Oscillator dividers
		next_st.div_fast = (st.div_fast == DIV_FAST_LAST) ? 4'h0 : st.div_fast + 4'h1;
		next_st.div_slow = (st.div_slow == DIV_SLOW_LAST) ? 4'h0 : st.div_slow + 4'h1;

		// Timer 0
		if (tick[0] && run[0]) begin
			case (t0_mode)
				MODE_PRESCALE: begin
					sum_lo = {4'h0, st.timer0_low_byte[4:0]} + 9'h001;
					next_st.timer0_low_byte = {3'h0, sum_lo[4:0]};
					if (sum_lo[5]) begin
						sum_hi = {1'b0, st.timer0_high_byte} + 9'h001;
						next_st.timer0_high_byte = sum_hi[7:0];
						ovf[0] = sum_hi[8];
					end
				end
				MODE_SIXTEEN: begin
					sum_lo = {1'b0, st.timer0_low_byte} + 9'h001;
					next_st.timer0_low_byte = sum_lo[7:0];
					if (sum_lo[8]) begin
						sum_hi = {1'b0, st.timer0_high_byte} + 9'h001;
						next_st.timer0_high_byte = sum_hi[7:0];
						ovf[0] = sum_hi[8];
					end
				end
				MODE_RELOAD: begin
					sum_lo = {1'b0, st.timer0_low_byte} + 9'h001;
					next_st.timer0_low_byte = sum_lo[8] ? st.timer0_high_byte : sum_lo[7:0];
					ovf[0] = sum_lo[8];
				end
				default: begin
					sum_lo = {1'b0, st.timer0_low_byte} + 9'h001;
					next_st.timer0_low_byte = sum_lo[7:0];
					ovf[0] = sum_lo[8];
				end
			endcase
		end

		// Timer 0 high byte in split mode uses timer 1 run and overflow
		if (t0_mode == MODE_SPLIT && t1_tick && st.timer_control[TC_TR1]) begin
			sum_hi = {1'b0, st.timer0_high_byte} + 9'h001;
			next_st.timer0_high_byte = sum_hi[7:0];
			ovf[1] = sum_hi[8];
		end

		// Timer 1
		if (tick[1] && run[1] && t1_mode != MODE_SPLIT) begin
			sum_lo = {1'b0, st.timer1_low_byte} + 9'h001;
			case (t1_mode)
				MODE_PRESCALE: begin
					next_st.timer1_low_byte = {3'h0, 5'(st.timer1_low_byte[4:0] + 5'h01)};
					if (st.timer1_low_byte[4:0] == 5'h1F) begin
						next_st.timer1_high_byte = st.timer1_high_byte + 8'h01;
						ovf[1] = st.timer1_high_byte == 8'hFF;
					end
				end
				MODE_SIXTEEN: begin
					next_st.timer1_low_byte = sum_lo[7:0];
					if (sum_lo[8]) begin
						next_st.timer1_high_byte = st.timer1_high_byte + 8'h01;
						ovf[1] = st.timer1_high_byte == 8'hFF;
					end
				end
				default: begin
					next_st.timer1_low_byte = sum_lo[8] ? st.timer1_high_byte : sum_lo[7:0];
					ovf[1] = sum_lo[8];
				end
			endcase
		end

		// Register writes
		if (dir_req.wr && sfr_hit && st.cpu_clk_en && (!dir_req.bit_op || bit_ok)) begin
			case (dir_req.addr)
				ADDR_PORT0_LATCH:    next_st.port0_latch = dir_req.bit_op ? merged : dir_req.wdata;
				ADDR_STACK_POINTER:  next_st.stack_pointer = dir_req.wdata;
				ADDR_POINTER0_LOW:   next_st.pointer0_low = dir_req.wdata;
				ADDR_POINTER0_HIGH:  next_st.pointer0_high = dir_req.wdata;
				ADDR_POINTER1_LOW:   next_st.pointer1_low = dir_req.wdata;
				ADDR_POINTER1_HIGH:  next_st.pointer1_high = dir_req.wdata;
				ADDR_POINTER_SELECT: next_st.pointer_select = dir_req.wdata[PS_SELECT];
				ADDR_POWER_CONTROL:  next_st.power_control = dir_req.wdata & POWER_CONTROL_IMPL_MASK;
				ADDR_TIMER_CONTROL: begin
					next_st.timer_control = dir_req.bit_op ? merged : dir_req.wdata;
				end
				ADDR_TIMER_MODE:     next_st.timer_mode = dir_req.wdata;
				ADDR_TIMER0_LOW:     next_st.timer0_low_byte = dir_req.wdata;
				ADDR_TIMER1_LOW:     next_st.timer1_low_byte = dir_req.wdata;
				ADDR_TIMER0_HIGH:    next_st.timer0_high_byte = dir_req.wdata;
				ADDR_TIMER1_HIGH:    next_st.timer1_high_byte = dir_req.wdata;
				ADDR_CLOCK_CONTROL:  next_st.clock_control = dir_req.wdata;
				ADDR_POWER_MGMT:     next_st.internal_ram_enable = dir_req.wdata[PM_RAM_ENABLE];
				default: ;
			endcase
		end

		// Flag clears on vectoring, then hardware sets win
		if (vector_timer[0]) next_st.timer_control[TC_TF0] = 1'b0;
		if (vector_timer[1]) next_st.timer_control[TC_TF1] = 1'b0;
		if (ovf[0]) next_st.timer_control[TC_TF0] = 1'b1;
		if (ovf[1]) next_st.timer_control[TC_TF1] = 1'b1;
		for (int i = 0; i < 2; i++) begin
			if (st.timer_control[TC_IT0 + 2 * i]) begin
				if (vector_ext[i]) next_st.timer_control[TC_IE0 + 2 * i] = 1'b0;
				if (fall_int[i]) next_st.timer_control[TC_IE0 + 2 * i] = 1'b1;
			end else begin
				next_st.timer_control[TC_IE0 + 2 * i] = !st.int_pin_s[i];
			end
		end

		// Read data and external bus routing
		next_st.dir_rdata = sfr_hit ? sfr_read : scratch_q;
		next_st.ext_bus.rd = xdata_req.rd && !ram_hit && st.cpu_clk_en;
		next_st.ext_bus.wr = xdata_req.wr && !ram_hit && st.cpu_clk_en;
		next_st.ext_bus.addr = xdata_req.addr;
		next_st.ext_bus.wdata = xdata_req.wdata;
		next_st.xdata_ack = (xdata_req.rd || xdata_req.wr) && st.cpu_clk_en;
		if (xdata_req.rd && !ram_hit) begin
			next_st.xdata_rdata = ext_rdata;
		end else if (st.xdata_ack && !(st.ext_bus.rd || st.ext_bus.wr)) begin
			next_st.xdata_rdata = int_ram_q;
		end
		next_st.active_data_pointer = st.pointer_select ?
			{next_st.pointer1_high, next_st.pointer1_low} :
			{next_st.pointer0_high, next_st.pointer0_low};
		next_st.baud_double = next_st.power_control[PC_BAUD_DOUBLE];
		next_st.framing_error_select = next_st.power_control[PC_FE_SELECT];
		next_st.cpu_clk_en = !(next_st.power_control[PC_IDLE] ||
			next_st.power_control[PC_POWER_DOWN]);
		next_st.periph_clk_en = !next_st.power_control[PC_POWER_DOWN];
	end

	// ---------------------------------------------
	// State register
	// ---------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
			st.port0_latch <= RST_PORT0;
			st.stack_pointer <= RST_STACK;
			st.clock_control <= RST_CLOCK_CONTROL;
			st.internal_ram_enable <= 1'b0;
			st.int_pin_q <= 2'b11;
			st.int_pin_s <= 2'b11;
			st.int_pin_d <= 2'b11;
			st.cnt_pin_q <= 2'b11;
			st.cnt_pin_s <= 2'b11;
			st.cnt_pin_d <= 2'b11;
			st.cpu_clk_en <= 1'b1;
			st.periph_clk_en <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign xdata_rdata          = st.xdata_rdata;

	assign dir_rdata            = st.dir_rdata;
	assign xdata_ack            = st.xdata_ack;
	assign ext_bus              = st.ext_bus;
	assign active_data_pointer  = st.active_data_pointer;
	assign baud_double          = st.baud_double;
	assign framing_error_select = st.framing_error_select;
	assign cpu_clk_en           = st.cpu_clk_en;
	assign periph_clk_en        = st.periph_clk_en;

endmodule

/* hw/csfr_pkg.sv */
// Package: register map, fields, reset values and timing of the register bank
package csfr_pkg;

	// ---------------------------------------------
	// Register offsets
	// ---------------------------------------------
	localparam logic [7:0] ADDR_PORT0_LATCH     = 8'h80;
	localparam logic [7:0] ADDR_STACK_POINTER   = 8'h81;
	localparam logic [7:0] ADDR_POINTER0_LOW    = 8'h82;
	localparam logic [7:0] ADDR_POINTER0_HIGH   = 8'h83;
	localparam logic [7:0] ADDR_POINTER1_LOW    = 8'h84;
	localparam logic [7:0] ADDR_POINTER1_HIGH   = 8'h85;
	localparam logic [7:0] ADDR_POINTER_SELECT  = 8'h86;
	localparam logic [7:0] ADDR_POWER_CONTROL   = 8'h87;
	localparam logic [7:0] ADDR_TIMER_CONTROL   = 8'h88;
	localparam logic [7:0] ADDR_TIMER_MODE      = 8'h89;
	localparam logic [7:0] ADDR_TIMER0_LOW      = 8'h8A;
	localparam logic [7:0] ADDR_TIMER1_LOW      = 8'h8B;
	localparam logic [7:0] ADDR_TIMER0_HIGH     = 8'h8C;
	localparam logic [7:0] ADDR_TIMER1_HIGH     = 8'h8D;
	localparam logic [7:0] ADDR_CLOCK_CONTROL   = 8'h8E;
	localparam logic [7:0] ADDR_POWER_MGMT      = 8'hC4;
	localparam logic [7:0] SFR_BASE             = 8'h80;

	// ---------------------------------------------
	// Field positions
	// ---------------------------------------------
	localparam int PC_BAUD_DOUBLE   = 7;
	localparam int PC_FE_SELECT     = 6;
	localparam int PC_POWER_DOWN    = 1;
	localparam int PC_IDLE          = 0;
	localparam int TC_TF1           = 7;
	localparam int TC_TR1           = 6;
	localparam int TC_TF0           = 5;
	localparam int TC_TR0           = 4;
	localparam int TC_IE1           = 3;
	localparam int TC_IT1           = 2;
	localparam int TC_IE0           = 1;
	localparam int TC_IT0           = 0;
	localparam int TM_GATE          = 3;
	localparam int TM_COUNTER       = 2;
	localparam int CK_T1_CLOCK      = 4;
	localparam int CK_T0_CLOCK      = 3;
	localparam int PM_RAM_ENABLE    = 0;
	localparam int PS_SELECT        = 0;

	// ---------------------------------------------
	// Reset values and sizes
	// ---------------------------------------------
	localparam logic [7:0]  RST_PORT0          = 8'hFF;
	localparam logic [7:0]  RST_STACK          = 8'h07;
	localparam logic [7:0]  RST_ZERO           = 8'h00;
	localparam logic [7:0]  RST_CLOCK_CONTROL  = 8'h01;
	localparam logic [7:0]  UNIMPL_READ        = 8'hFF;
	localparam logic [7:0]  POWER_CONTROL_IMPL_MASK     = 8'hCF;
	localparam logic [15:0] INT_RAM_LAST       = 16'h03FF;
	localparam int          INT_RAM_WORDS      = 1024;
	localparam int          SCRATCH_WORDS      = 256;
	localparam logic [1:0]  MODE_PRESCALE      = 2'h0;
	localparam logic [1:0]  MODE_SIXTEEN       = 2'h1;
	localparam logic [1:0]  MODE_RELOAD        = 2'h2;
	localparam logic [1:0]  MODE_SPLIT         = 2'h3;

	// ---------------------------------------------
	// Timing
	// ---------------------------------------------
	localparam int         CLK_PERIOD_NS  = 10;
	localparam int         OSC_DIV_FAST   = 4;
	localparam int         OSC_DIV_SLOW   = 12;
	localparam logic [3:0] DIV_FAST_LAST  = 4'(OSC_DIV_FAST - 1);
	localparam logic [3:0] DIV_SLOW_LAST  = 4'(OSC_DIV_SLOW - 1);

	// ---------------------------------------------
	// Carriers
	// ---------------------------------------------
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic       bit_op;
		logic [2:0] bit_sel;
		logic [7:0] addr;
		logic [7:0] wdata;
	} csfr_dir_req_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} csfr_xdata_req_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} csfr_ext_bus_t;

	typedef struct packed {
		logic [7:0]  port0_latch;
		logic [7:0]  stack_pointer;
		logic [7:0]  pointer0_low;
		logic [7:0]  pointer0_high;
		logic [7:0]  pointer1_low;
		logic [7:0]  pointer1_high;
		logic        pointer_select;
		logic [7:0]  power_control;
		logic [7:0]  timer_control;
		logic [7:0]  timer_mode;
		logic [7:0]  timer0_low_byte;
		logic [7:0]  timer1_low_byte;
		logic [7:0]  timer0_high_byte;
		logic [7:0]  timer1_high_byte;
		logic [7:0]  clock_control;
		logic        internal_ram_enable;
		logic [3:0]  div_fast;
		logic [3:0]  div_slow;
		logic [1:0]  int_pin_q;
		logic [1:0]  int_pin_s;
		logic [1:0]  int_pin_d;
		logic [1:0]  cnt_pin_q;
		logic [1:0]  cnt_pin_s;
		logic [1:0]  cnt_pin_d;
		logic [7:0]  dir_rdata;
		logic [7:0]  xdata_rdata;
		logic        xdata_ack;
		csfr_ext_bus_t ext_bus;
		logic [15:0] active_data_pointer;
		logic        baud_double;
		logic        framing_error_select;
		logic        cpu_clk_en;
		logic        periph_clk_en;
	} csfr_state_t;

endpackage

/* test/csfr_bank_asserts.sv */
// Checker: port-level relations of the register bank
`timescale 1ns/1ns
module csfr_bank_asserts
	import csfr_pkg::*;
(
	input  wire logic            core_clk,
	input  wire logic            arst_n,
	input  wire csfr_dir_req_t   dir_req,
	input  wire logic            dir_indirect,
	input  wire logic [7:0]      dir_rdata,
	input  wire csfr_xdata_req_t xdata_req,
	input  wire logic            xdata_ack,
	input  wire csfr_ext_bus_t   ext_bus,
	input  wire logic            baud_double,
	input  wire logic            framing_error_select,
	input  wire logic            cpu_clk_en,
	input  wire logic            periph_clk_en
);
	// --------
	// Helpers
	// --------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	logic xreq;
	logic dread;
	logic power_control_wr;
	assign xreq = xdata_req.rd | xdata_req.wr;
	assign dread = dir_req.rd & !dir_indirect;
	assign power_control_wr = dir_req.wr & !dir_req.bit_op & !dir_indirect & cpu_clk_en
		& (dir_req.addr == ADDR_POWER_CONTROL);

	// --------
	// Assertions
	// --------
	a_external_data_move_ack: assert property (xreq |=> xdata_ack)
		else $error("no ack after external_data_move request");
	a_external_data_move_quiet: assert property (!xreq |=> !xdata_ack && !ext_bus.rd && !ext_bus.wr)
		else $error("external_data_move output without request");
	a_high_external: assert property (xreq && xdata_req.addr > INT_RAM_LAST |=>
		ext_bus.rd == $past(xdata_req.rd) && ext_bus.wr == $past(xdata_req.wr)
		&& ext_bus.addr == $past(xdata_req.addr))
		else $error("high external_data_move address not sent out");
	a_high_wdata: assert property (xdata_req.wr && xdata_req.addr > INT_RAM_LAST |=>
		ext_bus.wdata == $past(xdata_req.wdata))
		else $error("external write data wrong");
	a_select_reserved: assert property (dread && dir_req.addr == ADDR_POINTER_SELECT |=>
		dir_rdata[7:1] == 7'h00)
		else $error("pointer select upper bits not zero");
	a_unimpl_ones: assert property (dread && dir_req.addr == 8'h8F |=> dir_rdata == UNIMPL_READ)
		else $error("unimplemented location not all ones");
	a_power_control_gaps: assert property (dread && dir_req.addr == ADDR_POWER_CONTROL |=>
		dir_rdata[5:4] == 2'h3)
		else $error("power control gap bits not one");
	a_pd_all_stop: assert property (!periph_clk_en |-> !cpu_clk_en)
		else $error("cpu clock runs in power down");
	a_idle_request: assert property (power_control_wr && dir_req.wdata[0] |-> ##2 !cpu_clk_en)
		else $error("idle did not stop cpu clock");
	a_baud_copy: assert property (power_control_wr |-> ##2 baud_double == $past(dir_req.wdata[7], 2)
		&& framing_error_select == $past(dir_req.wdata[6], 2))
		else $error("serial control copies wrong");

	// --------
	// Covers
	// --------
	c_internal: cover property (xreq && xdata_req.addr <= INT_RAM_LAST ##1 xdata_ack);
	c_idle: cover property (!cpu_clk_en && periph_clk_en);
	c_power_down: cover property (!periph_clk_en);
endmodule

/* test/csfr_ext_mem.sv */
// Partner: external data memory on the multiplexed bus
`timescale 1ns/1ns
module csfr_ext_mem
	import csfr_pkg::*;
(
	input  wire logic            core_clk,
	input  wire csfr_xdata_req_t xdata_req,
	input  wire csfr_ext_bus_t   ext_bus,
	output logic [7:0]           ext_rdata
);
	logic [7:0] mem [256];
	logic [7:0] last;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'hA5;
		end
		last = 8'h00;
	end
	// Read data on request, else a changing pattern
	always_comb begin
		if (xdata_req.rd) begin
			ext_rdata = mem[xdata_req.addr[7:0]];
		end else if (ext_bus.rd) begin
			ext_rdata = mem[ext_bus.addr[7:0]];
		end else begin
			ext_rdata = ~last;
		end
	end
	always @(posedge core_clk) begin
		last <= ext_rdata;
		if (ext_bus.wr) begin
			mem[ext_bus.addr[7:0]] <= ext_bus.wdata;
		end
	end
endmodule

/* test/tb_core_sfr_bank_timer01.sv */
// Testbench: register bank scenarios
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
	$display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_core_sfr_bank_timer01
	import csfr_pkg::*;
;
	logic            core_clk;
	logic            arst_n;
	csfr_dir_req_t   dir_req;
	logic            dir_indirect;
	logic [7:0]      dir_rdata;
	csfr_xdata_req_t xdata_req;
	logic [7:0]      xdata_rdata;
	logic            xdata_ack;
	csfr_ext_bus_t   ext_bus;
	logic [7:0]      ext_rdata;
	logic [1:0]      vector_timer;
	logic [1:0]      vector_ext;
	logic [1:0]      external_interrupt_pin;
	logic [1:0]      count_pin;
	logic [15:0]     active_data_pointer;
	logic            baud_double;
	logic            framing_error_select;
	logic            cpu_clk_en;
	logic            periph_clk_en;
	int              fails;
	int              n_compared;
	logic [7:0]      v;
	logic            ext;

	csfr_bank csfr_bank_inst (.core_clk(core_clk), .arst_n(arst_n), .dir_req(dir_req),
		.dir_indirect(dir_indirect), .dir_rdata(dir_rdata), .xdata_req(xdata_req),
		.xdata_rdata(xdata_rdata), .xdata_ack(xdata_ack), .ext_bus(ext_bus),
		.ext_rdata(ext_rdata), .vector_timer(vector_timer), .vector_ext(vector_ext),
		.external_interrupt_pin(external_interrupt_pin), .count_pin(count_pin),
		.active_data_pointer(active_data_pointer), .baud_double(baud_double),
		.framing_error_select(framing_error_select), .cpu_clk_en(cpu_clk_en),
		.periph_clk_en(periph_clk_en));
	csfr_ext_mem csfr_ext_mem_inst (.core_clk(core_clk), .xdata_req(xdata_req),
		.ext_bus(ext_bus), .ext_rdata(ext_rdata));

	initial begin
		core_clk = 1'b0;
		forever #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
	end

	// --------
	// Bus tasks
	// --------
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d, input logic bo = 1'b0,
		input logic [2:0] sel = 3'h0);
		@(posedge core_clk); #1;
		dir_req.wr = 1'b1; dir_req.addr = a; dir_req.wdata = d;
		dir_req.bit_op = bo; dir_req.bit_sel = sel;
		@(posedge core_clk); #1;
		dir_req.wr = 1'b0; dir_req.bit_op = 1'b0;
	endtask
	task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk); #1;
		dir_req.rd = 1'b1; dir_req.addr = a;
		@(posedge core_clk); #1;
		d = dir_rdata; dir_req.rd = 1'b0;
	endtask
	task automatic external_data_move(input logic w, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic e);
		@(posedge core_clk); #1;
		xdata_req.rd = !w; xdata_req.wr = w; xdata_req.addr = a; xdata_req.wdata = d;
		@(posedge core_clk); #1;
		xdata_req.rd = 1'b0; xdata_req.wr = 1'b0;
		e = ext_bus.rd | ext_bus.wr; q = xdata_rdata;
		if (!e) begin
			@(posedge core_clk); #1;
			q = xdata_rdata;
		end
	endtask
	task automatic do_reset();
		arst_n = 1'b0;
		repeat (12) @(posedge core_clk);
		#1 arst_n = 1'b1;
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge core_clk); #1 count_pin[0] = 1'b0;
			repeat (4) @(posedge core_clk);
			#1 count_pin[0] = 1'b1;
			repeat (4) @(posedge core_clk);
		end
	endtask
	task automatic poll_tf0(output int n);
		n = 0;
		do begin sfr_rd(ADDR_TIMER_CONTROL, v); n++; end while (!v[TC_TF0] && n < 30);
	endtask

	// --------
	// Scenarios
	// --------
	task automatic t_reset_values();
		logic [7:0] ad [9] = '{8'h80, 8'h81, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8E, 8'hC4, 8'h8F};
		logic [7:0] ex [9] = '{8'hFF, 8'h07, 8'h00, 8'h30, 8'h00, 8'h00, 8'h01, 8'hFE, 8'hFF};
		for (int i = 0; i < 9; i++) begin
			sfr_rd(ad[i], v);
			`CHK(v, ex[i])
		end
	endtask
	task automatic t_pointers();
		sfr_wr(ADDR_POINTER0_LOW, 8'h34); sfr_wr(ADDR_POINTER0_HIGH, 8'h12);
		sfr_wr(ADDR_POINTER1_LOW, 8'h78); sfr_wr(ADDR_POINTER1_HIGH, 8'h56);
		sfr_wr(ADDR_POINTER_SELECT, 8'hFF);
		sfr_rd(ADDR_POINTER_SELECT, v);
		`CHK(v, 8'h01)
		`CHK(active_data_pointer, 16'h5678)
		sfr_wr(ADDR_POINTER_SELECT, 8'h00);
		repeat (2) @(posedge core_clk);
		#1 `CHK(active_data_pointer, 16'h1234)
	endtask
	task automatic t_bits();
		sfr_wr(ADDR_STACK_POINTER, 8'hAA);
		sfr_wr(ADDR_STACK_POINTER, 8'hFF, 1'b1, 3'h0);
		@(posedge core_clk); #1 dir_indirect = 1'b1;
		sfr_wr(ADDR_STACK_POINTER, 8'h55);
		sfr_rd(ADDR_STACK_POINTER, v);
		`CHK(v, 8'h55)
		@(posedge core_clk); #1 dir_indirect = 1'b0;
		sfr_rd(ADDR_STACK_POINTER, v);
		`CHK(v, 8'hAA)
		sfr_wr(ADDR_TIMER_CONTROL, 8'hFF, 1'b1, 3'(TC_IT1));
		sfr_rd(ADDR_TIMER_CONTROL, v);
		`CHK(v, 8'h04)
		sfr_wr(ADDR_TIMER_CONTROL, 8'h00, 1'b1, 3'(TC_IT1));
		sfr_rd(ADDR_TIMER_CONTROL, v);
		`CHK(v, 8'h00)
	endtask
	task automatic t_external_data_move();
		logic [15:0] ad [7] = '{16'h0010, 16'h0010, 16'h0010, 16'h0010, 16'h03FF, 16'h03FF, 16'h0400};
		logic [7:0]  dt [7] = '{8'h77, 8'h77, 8'h5A, 8'h5A, 8'hC3, 8'hC3, 8'hA5};
		logic        ee [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
		for (int i = 0; i < 7; i++) begin
			if (i == 2) sfr_wr(ADDR_POWER_MGMT, 8'h01);
			external_data_move(!i[0], ad[i], dt[i], v, ext);
			`CHK(ext, ee[i])
			if (i[0]) `CHK(v, dt[i])
		end
	endtask
	task automatic t_timer();
		int n;
		logic [7:0] w;
		sfr_wr(ADDR_CLOCK_CONTROL, 8'h08); sfr_wr(ADDR_TIMER_MODE, 8'h01);
		sfr_wr(ADDR_TIMER0_LOW, 8'hFE); sfr_wr(ADDR_TIMER0_HIGH, 8'hFF);
		sfr_wr(ADDR_TIMER_CONTROL, 8'h10);
		poll_tf0(n);
		`CHK(n <= 8, 1'b1)
		@(posedge core_clk); #1 vector_timer = 2'h1;
		@(posedge core_clk); #1 vector_timer = 2'h0;
		sfr_rd(ADDR_TIMER_CONTROL, v);
		`CHK(v[TC_TF0], 1'b0)
		sfr_wr(ADDR_TIMER_CONTROL, 8'h00); sfr_rd(ADDR_TIMER0_LOW, w);
		repeat (20) @(posedge core_clk);
		sfr_rd(ADDR_TIMER0_LOW, v);
		`CHK(v, w)
		sfr_wr(ADDR_TIMER_MODE, 8'h02); sfr_wr(ADDR_TIMER0_HIGH, 8'hF0);
		sfr_wr(ADDR_TIMER0_LOW, 8'hFE); sfr_wr(ADDR_TIMER_CONTROL, 8'h10);
		poll_tf0(n);
		sfr_wr(ADDR_TIMER_CONTROL, 8'h00); sfr_rd(ADDR_TIMER0_LOW, v);
		`CHK(v >= 8'hF0 && v <= 8'hF4, 1'b1)
	endtask
	task automatic t_counter();
		sfr_wr(ADDR_TIMER_MODE, 8'h04); sfr_wr(ADDR_TIMER0_LOW, 8'h00);
		sfr_wr(ADDR_TIMER_CONTROL, 8'h10);
		pulses(3); sfr_rd(ADDR_TIMER0_LOW, v);
		`CHK(v, 8'h03)
		sfr_wr(ADDR_TIMER_MODE, 8'h0D);
		@(posedge core_clk); #1 external_interrupt_pin[0] = 1'b0;
		pulses(3); sfr_rd(ADDR_TIMER0_LOW, v);
		`CHK(v, 8'h03)
		sfr_rd(ADDR_TIMER_CONTROL, v);
		`CHK(v[TC_IE0], 1'b1)
		@(posedge core_clk); #1 external_interrupt_pin[0] = 1'b1;
		pulses(3); sfr_rd(ADDR_TIMER0_LOW, v);
		`CHK(v, 8'h06)
		sfr_rd(ADDR_TIMER_CONTROL, v);
		`CHK(v[TC_IE0], 1'b0)
		sfr_wr(ADDR_TIMER_CONTROL, 8'h01);
		@(posedge core_clk); #1 external_interrupt_pin[0] = 1'b0;
		repeat (6) @(posedge core_clk);
		#1 external_interrupt_pin[0] = 1'b1;
		repeat (6) @(posedge core_clk);
		sfr_rd(ADDR_TIMER_CONTROL, v);
		`CHK(v[TC_IE0], 1'b1)
		@(posedge core_clk); #1 vector_ext = 2'h1;
		@(posedge core_clk); #1 vector_ext = 2'h0;
		sfr_rd(ADDR_TIMER_CONTROL, v);
		`CHK(v[TC_IE0], 1'b0)
	endtask
	task automatic t_power();
		sfr_wr(ADDR_POWER_CONTROL, 8'hC1);
		repeat (3) @(posedge core_clk);
		#1 `CHK({cpu_clk_en, periph_clk_en}, 2'b01)
		`CHK({baud_double, framing_error_select}, 2'b11)
		do_reset();
		sfr_wr(ADDR_POWER_CONTROL, 8'h02);
		repeat (3) @(posedge core_clk);
		#1 `CHK({cpu_clk_en, periph_clk_en}, 2'b00)
	endtask

	// --------
	// Sequence and verdict
	// --------
	task automatic summarize();
		if (fails == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		fails = 0; n_compared = 0; dir_req = '0; dir_indirect = 1'b0; xdata_req = '0;
		vector_timer = 2'h0; vector_ext = 2'h0; external_interrupt_pin = 2'h3; count_pin = 2'h3;
		do_reset();
		t_reset_values(); t_pointers(); t_bits(); t_external_data_move();
		t_timer(); t_counter(); t_power();
		summarize();
	end
	initial begin
		#200000;
		fails++;
		summarize();
	end
endmodule

bind csfr_bank csfr_bank_asserts csfr_bank_asserts_inst (.core_clk(core_clk), .arst_n(arst_n),
	.dir_req(dir_req), .dir_indirect(dir_indirect), .dir_rdata(dir_rdata),
	.xdata_req(xdata_req), .xdata_ack(xdata_ack), .ext_bus(ext_bus),
	.baud_double(baud_double), .framing_error_select(framing_error_select),
	.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en));
